/* File: design/tpf_consts.svh */
`ifndef TPF_CONSTS_SVH
`define TPF_CONSTS_SVH
// Partition select width and partition count
`define TPF_PART_W        3
`define TPF_NUM_PART      8
// Words per 128-bit buffer line and lane counts
`define TPF_WORDS_LINE    4
`define TPF_WORD_W        32
`define TPF_BE_W          4
`define TPF_PORT_W        8
// Lines per partition and full threshold in lines
`define TPF_LINES_PART    16
`define TPF_FILL_LEVEL    12
// Byte-valid values
`define TPF_BE_FULL       4'h0F
`define TPF_BE_NONE       4'h00
// Write clock: period in ns, core clock period in ns, half period in core cycles
`define TPF_WCLK_NS       160
`define TPF_CORE_NS       20
`define TPF_WCLK_HALF     ((`TPF_WCLK_NS / `TPF_CORE_NS) / 2)
`endif

/* File: design/tpf_dev.sv */
`timescale 1ns/100ps
`include "tpf_consts.svh"
// Overview of operation
// - Three-bit select picks one of eight partitions
// - Any port may share any partition
// - Four 32-bit writes build one 128-bit line
// - Writer sends four per line unless ending; here also cut short by terminate
// - Flag n qualifies byte lane n
// - All flags low: word dropped, nothing written
// - Writer keeps all flags high except last
// - Writer's flag patterns contiguous from top lane
// - Start mark begins a packet for port
// - Writer raises start mark on line's first write
// - Writer may end packet on any word
// - End mark advances pointer to next line
// - Error mark flags current packet bad
// - Writer raises error mark only with end
// - Strobe high commits word into buffer
// - Eight-bit port number travels with word
// - Line terminate forces pointer to next line
// - Disable stops draining, link idles, buffer fills
// - Full flag for selected partition at or over threshold
// - Write clock independent of other write clocks
module tpf_dev #(
  parameter int NP    = `TPF_NUM_PART,
  parameter int LINES = `TPF_LINES_PART,
  parameter int FILL  = `TPF_FILL_LEVEL
) (
  input  wire logic         CORE_CLK,    // Core clock
  input  wire logic         RST_B,       // Async reset, active low
  tpf_if.dev                wif,         // Fabric write pins
  input  wire logic         LINE_READY,  // Link side takes the line
  output logic              LINE_VALID,  // A line is offered
  output logic [127:0]      LINE_DATA,   // Word 0 in bits 127:96
  output logic [15:0]       LINE_BE,     // Lane flags, word 0 in bits 15:12
  output logic              LINE_SOP,    // Line starts a packet
  output logic              LINE_EOP,    // Line ends a packet
  output logic              LINE_ERR,    // Packet ended in error
  output logic [7:0]        LINE_PORT,   // Port of the line
  output logic [2:0]        LINE_PART,   // Partition the line came from
  output logic              LINK_IDLE    // Link sends idle
);
  localparam int PW   = $clog2(NP);
  localparam int LW   = $clog2(LINES);
  localparam int CW   = LW + 1;
  localparam int IN_W = 54;
  localparam int MW   = 27;

  initial begin
    if (NP < 2 || NP > `TPF_NUM_PART || (1 << PW) != NP) begin
      $error("Partition count must be a power of two up to eight");
    end
    if ((1 << LW) != LINES || LINES < 2) begin
      $error("Lines per partition must be a power of two");
    end
    if (FILL < 1 || FILL > LINES) begin
      $error("Fill level out of range");
    end
  end

  typedef struct packed {
    logic        clk;
    logic [2:0]  sel;
    logic [31:0] data;
    logic [3:0]  be;
    logic        sop;
    logic        eop;
    logic        err;
    logic        we;
    logic [7:0]  port;
    logic        term;
    logic        dis;
  } pins_t;

  typedef struct packed {
    logic [IN_W-1:0]       s1;
    logic [IN_W-1:0]       s2;
    logic                  clk_d;
    logic [NP-1:0][CW-1:0] fill;
    logic [NP-1:0][LW-1:0] rd_ptr;
    logic [PW-1:0]         rr;
    logic                  full;
    logic                  vld;
    logic [127:0]          data;
    logic [15:0]           be;
    logic                  sop;
    logic                  eop;
    logic                  err;
    logic [7:0]            port;
    logic [2:0]            part;
    logic                  idle;
  } dev_st_t;

  dev_st_t st_r;
  dev_st_t st_nxt;

  // Buffer memory: one word per slot, and per-line sideband
  logic [31:0]   word_mem [NP*LINES*`TPF_WORDS_LINE];
  logic [MW-1:0] meta_mem [NP*LINES];

  pins_t         pin;
  logic          rise;
  logic [PW-1:0] wpart;
  logic          room;
  logic          acc_wr;
  logic          acc_term;
  logic [1:0]    word_idx;
  logic [LW-1:0] line_idx;
  logic          commit;
  logic          rd_take;
  logic [PW+LW-1:0] wline;
  logic [PW+LW-1:0] rline;
  logic [MW-1:0] meta_old;
  logic [MW-1:0] meta_new;
  logic [15:0]   be_new;

  // All pins cross in as one bundle; only the second stage is read
  assign pin   = pins_t'(st_r.s2);
  assign rise  = pin.clk & ~st_r.clk_d;
  assign wpart = pin.sel[PW-1:0];
  assign room  = st_r.fill[wpart] != CW'(LINES);
  // Overflow is dropped: the writer is expected to watch the full flag
  assign acc_wr   = rise & pin.we & (pin.be != `TPF_BE_NONE) & room;
  assign acc_term = rise & pin.term & room;

  tpf_line_asm #(
    .NP    (NP),
    .LINES (LINES)
  ) u_asm (
    .clk      (CORE_CLK),
    .rst_b    (RST_B),
    .part     (wpart),
    .wr       (acc_wr),
    .eop      (pin.eop),
    .term     (acc_term),
    .word_idx (word_idx),
    .line_idx (line_idx),
    .commit   (commit)
  );

  // Sideband merge: first word clears the line, later words add lanes
  always_comb begin
    wline    = {wpart, line_idx};
    meta_old = meta_mem[wline];
    be_new   = (word_idx == 2'h0) ? 16'h0000 : meta_old[26:11];
    meta_new = meta_old;
    if (acc_wr) begin
      be_new[4'(12 - 4 * word_idx) +: 4] = pin.be;
      meta_new = {be_new,
                  (word_idx == 2'h0) ? pin.sop : meta_old[10],
                  pin.eop,
                  pin.eop & pin.err,
                  pin.port};
    end else if (word_idx == 2'h0) begin
      meta_new = '0; // Terminate on an empty line leaves an empty line
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (acc_wr) begin
      word_mem[{wline, word_idx}] <= pin.data;
    end
    if (acc_wr | acc_term) begin
      meta_mem[wline] <= meta_new;
    end
  end

  // Drain one committed line at a time, round robin; held off while disabled
  always_comb begin
    st_nxt       = st_r;
    st_nxt.s1    = {wif.tx_write_clock, wif.partition_select, wif.write_word,
                    wif.byte_valid_flags, wif.packet_start_mark, wif.packet_end_mark,
                    wif.packet_error_mark, wif.write_strobe, wif.logical_port_number,
                    wif.line_terminate, wif.buffer_service_disable};
    st_nxt.s2    = st_r.s1;
    st_nxt.clk_d = pin.clk;
    rline        = {st_r.rr, st_r.rd_ptr[st_r.rr]};
    rd_take      = (~st_r.vld | LINE_READY) & ~pin.dis & (st_r.fill[st_r.rr] != '0);
    if (st_r.vld & LINE_READY) begin
      st_nxt.vld = 1'b0;
    end
    if (rd_take) begin
      st_nxt.vld  = 1'b1;
      for (int w = 0; w < `TPF_WORDS_LINE; w++) begin
        st_nxt.data[96 - 32 * w +: 32] = word_mem[{rline, 2'(w)}];
      end
      {st_nxt.be, st_nxt.sop, st_nxt.eop, st_nxt.err, st_nxt.port} = meta_mem[rline];
      st_nxt.part = 3'(st_r.rr);
      st_nxt.rd_ptr[st_r.rr] = st_r.rd_ptr[st_r.rr] + LW'(1);
    end
    // A partition with nothing ready or just served passes the turn on
    if (rd_take | (st_r.fill[st_r.rr] == '0)) begin
      st_nxt.rr = st_r.rr + PW'(1);
    end
    for (int p = 0; p < NP; p++) begin
      st_nxt.fill[p] = st_r.fill[p]
                       + CW'(commit && wpart == PW'(p))
                       - CW'(rd_take && st_r.rr == PW'(p));
    end
    st_nxt.full = st_r.fill[wpart] >= CW'(FILL);
    st_nxt.idle = pin.dis | ~st_nxt.vld;
  end

  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      st_r      <= '0;
      st_r.idle <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign wif.partition_full_flag = st_r.full;
  assign LINE_VALID = st_r.vld;
  assign LINE_DATA  = st_r.data;
  assign LINE_BE    = st_r.be;
  assign LINE_SOP   = st_r.sop;
  assign LINE_EOP   = st_r.eop;
  assign LINE_ERR   = st_r.err;
  assign LINE_PORT  = st_r.port;
  assign LINE_PART  = st_r.part;
  assign LINK_IDLE  = st_r.idle;
endmodule

/* File: design/tpf_host.sv */
`timescale 1ns/100ps
`include "tpf_consts.svh"
module tpf_host #(
  parameter int HALF = `TPF_WCLK_HALF
) (
  input  wire logic        CORE_CLK,     // Core clock
  input  wire logic        RST_B,        // Async reset, active low
  tpf_if.host              wif,          // Write pins toward the buffer
  input  wire logic        USR_VALID,    // Word or terminate offered
  output logic             USR_READY,    // Offer taken this cycle
  input  wire logic [31:0] USR_DATA,     // Word data
  input  wire logic [3:0]  USR_BE,       // Lane flags for a final word
  input  wire logic        USR_SOP,      // Word starts a packet
  input  wire logic        USR_EOP,      // Word ends a packet
  input  wire logic        USR_ERR,      // Packet in error
  input  wire logic        USR_TERM,     // Offer is a line terminate only
  input  wire logic [7:0]  USR_PORT,     // Port of the word
  input  wire logic [2:0]  USR_PART,     // Target partition
  input  wire logic        USR_DISABLE,  // Stop buffer draining
  output logic             USR_FULL      // Selected partition full
);
  localparam int DW = $clog2(HALF + 1);

  initial begin
    if (HALF < 2) begin
      $error("Write clock half period must be at least two core cycles");
    end
  end

  typedef struct packed {
    logic [DW-1:0]     div;
    logic              wclk;
    tpf_pkg::tpf_hstate_t st;
    tpf_pkg::tpf_word_t   pend;
    logic [7:0][1:0]   wcnt;
    logic              full_s1;
    logic              full_s2;
    logic [2:0]        sel;
    logic [31:0]       data;
    logic [3:0]        be;
    logic              sop;
    logic              eop;
    logic              err;
    logic              we;
    logic [7:0]        port;
    logic              term;
    logic              dis;
  } host_st_t;

  host_st_t st_r;
  host_st_t st_nxt;
  logic     fall;

  assign fall      = st_r.wclk && st_r.div == DW'(HALF - 1);
  assign USR_READY = st_r.st == tpf_pkg::TPF_H_EMPTY;

  // Pins other than the disable change only as the write clock falls, so they are steady at its rise
  always_comb begin
    st_nxt         = st_r;
    st_nxt.full_s1 = wif.partition_full_flag;
    st_nxt.full_s2 = st_r.full_s1;
    st_nxt.dis     = USR_DISABLE;
    st_nxt.div     = (st_r.div == DW'(HALF - 1)) ? '0 : st_r.div + DW'(1);
    if (st_r.div == DW'(HALF - 1)) begin
      st_nxt.wclk = ~st_r.wclk;
    end
    if (USR_VALID && st_r.st == tpf_pkg::TPF_H_EMPTY) begin
      st_nxt.pend = '{USR_DATA, USR_BE, USR_SOP, USR_EOP, USR_ERR, USR_TERM, USR_PORT,
                      USR_PART};
      st_nxt.st   = tpf_pkg::TPF_H_HELD;
    end
    if (fall) begin
      st_nxt.we   = 1'b0;
      st_nxt.term = 1'b0;
      if (st_r.st == tpf_pkg::TPF_H_HELD) begin
        // Select moves to the held offer's partition, even while full holds the word back
        st_nxt.sel = st_r.pend.part;
        priority case (1'b1)
          // Close a partly written line before a new packet or on request
          st_r.pend.term, st_r.pend.sop && st_r.wcnt[st_r.pend.part] != 2'h0: begin
            st_nxt.term = 1'b1;
            st_nxt.wcnt[st_r.pend.part] = 2'h0;
            if (st_r.pend.term) begin
              st_nxt.st = tpf_pkg::TPF_H_EMPTY;
            end
          end
          // Full status lags by a few cycles; hold the word while it shows
          st_r.full_s2: begin
            st_nxt.we = 1'b0;
          end
          default: begin
            st_nxt.we   = 1'b1;
            st_nxt.data = st_r.pend.data;
            st_nxt.port = st_r.pend.port;
            st_nxt.sop  = st_r.pend.sop;
            st_nxt.eop  = st_r.pend.eop;
            st_nxt.err  = st_r.pend.err & st_r.pend.eop;
            for (int i = 0; i < 4; i++) begin
              st_nxt.be[i] = st_r.pend.eop ? |(st_r.pend.be << (3 - i)) : 1'b1;
            end
            st_nxt.wcnt[st_r.pend.part] = st_r.pend.eop ? 2'h0
                                          : st_r.wcnt[st_r.pend.part] + 2'h1;
            st_nxt.st = tpf_pkg::TPF_H_EMPTY;
          end
        endcase
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign wif.tx_write_clock         = st_r.wclk;
  assign wif.partition_select       = st_r.sel;
  assign wif.write_word             = st_r.data;
  assign wif.byte_valid_flags       = st_r.be;
  assign wif.packet_start_mark      = st_r.sop;
  assign wif.packet_end_mark        = st_r.eop;
  assign wif.packet_error_mark      = st_r.err;
  assign wif.write_strobe           = st_r.we;
  assign wif.logical_port_number    = st_r.port;
  assign wif.line_terminate         = st_r.term;
  assign wif.buffer_service_disable = st_r.dis;
  assign USR_FULL                   = st_r.full_s2;
endmodule

/* File: design/tpf_if.sv */
`timescale 1ns/100ps
interface tpf_if;
  logic        tx_write_clock;         // Write clock made by the fabric end
  logic [2:0]  partition_select;       // Virtual partition addressed
  logic [31:0] write_word;             // Write data
  logic [3:0]  byte_valid_flags;       // Lane qualifiers, bit 3 is bits 31:24
  logic        packet_start_mark;      // First word of a packet
  logic        packet_end_mark;        // Last word of a packet
  logic        packet_error_mark;      // Packet in error, with end mark
  logic        write_strobe;           // Word is valid this write clock
  logic [7:0]  logical_port_number;    // Port owning the word
  logic        line_terminate;         // Force pointer to next line
  logic        buffer_service_disable; // Stop draining the buffer
  logic        partition_full_flag;    // Selected partition at or above threshold

  modport dev (
    input  tx_write_clock, partition_select, write_word, byte_valid_flags,
    input  packet_start_mark, packet_end_mark, packet_error_mark, write_strobe,
    input  logical_port_number, line_terminate, buffer_service_disable,
    output partition_full_flag
  );
  modport host (
    output tx_write_clock, partition_select, write_word, byte_valid_flags,
    output packet_start_mark, packet_end_mark, packet_error_mark, write_strobe,
    output logical_port_number, line_terminate, buffer_service_disable,
    input  partition_full_flag
  );
endinterface

/* File: design/tpf_line_asm.sv */
`timescale 1ns/100ps
`include "tpf_consts.svh"
module tpf_line_asm #(
  parameter int NP    = `TPF_NUM_PART,
  parameter int LINES = `TPF_LINES_PART
) (
  input  wire logic                     clk,       // Core clock
  input  wire logic                     rst_b,     // Async reset, active low
  input  wire logic [$clog2(NP)-1:0]    part,      // Partition of this event
  input  wire logic                     wr,        // Accepted non-empty write
  input  wire logic                     eop,       // End mark with the write
  input  wire logic                     term,      // Line terminate request
  output logic      [1:0]               word_idx,  // Word slot in current line
  output logic      [$clog2(LINES)-1:0] line_idx,  // Current line of partition
  output logic                          commit     // Line closes this cycle
);
  localparam int LW = $clog2(LINES);

  typedef struct packed {
    logic [NP-1:0][1:0]    wcnt;
    logic [NP-1:0][LW-1:0] wptr;
  } asm_st_t;

  asm_st_t st_r;
  asm_st_t st_nxt;

  // Lines close on the fourth word, on an end mark, or on a terminate
  always_comb begin
    st_nxt   = st_r;
    word_idx = st_r.wcnt[part];
    line_idx = st_r.wptr[part];
    commit   = term | (wr & (eop | (st_r.wcnt[part] == 2'(`TPF_WORDS_LINE - 1))));
    if (commit) begin
      st_nxt.wcnt[part] = 2'h0;
      st_nxt.wptr[part] = st_r.wptr[part] + LW'(1); // Wraps inside the partition
    end else if (wr) begin
      st_nxt.wcnt[part] = st_r.wcnt[part] + 2'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule

/* File: design/tpf_pkg.sv */
package tpf_pkg;
  // One word as the fabric side hands it over
  typedef struct packed {
    logic [31:0] data;
    logic [3:0]  be;
    logic        sop;
    logic        eop;
    logic        err;
    logic        term;
    logic [7:0]  port;
    logic [2:0]  part;
  } tpf_word_t;

  // Writer end: waiting for a word, or holding one for the next write clock
  typedef enum logic [0:0] {
    TPF_H_EMPTY,
    TPF_H_HELD
  } tpf_hstate_t;
endpackage

/* File: tb/tpf_checker.sv */
`timescale 1ns/100ps
// Watches the write pins between the writer end and the device end
module tpf_checker #(
  parameter int FILL = 12
) (
  input logic        CORE_CLK,               // Core clock
  input logic        RST_B,                  // Async reset, active low
  input logic        tx_write_clock,         // Write clock
  input logic [2:0]  partition_select,       // Partition addressed
  input logic [31:0] write_word,             // Write data
  input logic [3:0]  byte_valid_flags,       // Lane flags
  input logic        packet_start_mark,      // Start mark
  input logic        packet_end_mark,        // End mark
  input logic        packet_error_mark,      // Error mark
  input logic        write_strobe,           // Word valid
  input logic [7:0]  logical_port_number,    // Port number
  input logic        line_terminate,         // Line terminate
  input logic        buffer_service_disable, // Drain disable
  input logic        partition_full_flag     // Full status
);
  logic       wclk_q;
  logic [1:0] cnt_r [8];
  logic [7:0] lines_r [8];
  logic       rise;
  logic       wr;
  logic       close;

  // A line closes on terminate, on end mark, or after its fourth word
  assign rise  = tx_write_clock && !wclk_q;
  assign wr    = write_strobe && (byte_valid_flags != 4'h0);
  assign close = line_terminate || (wr && (packet_end_mark || cnt_r[partition_select] == 2'h3));

  // Shadow slot count per partition; line total never falls, so full can be bounded by it
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      wclk_q  <= 1'b0;
      cnt_r   <= '{default: 2'h0};
      lines_r <= '{default: 8'h00};
    end else begin
      wclk_q <= tx_write_clock;
      if (rise && close) begin
        cnt_r[partition_select]   <= 2'h0;
        lines_r[partition_select] <= lines_r[partition_select] + 8'h01;
      end else if (rise && wr) begin
        cnt_r[partition_select] <= cnt_r[partition_select] + 2'h1;
      end
    end
  end

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_B);

  // A word stands through one low phase and one high phase of the write clock
  sequence s_low;
    (write_strobe && !tx_write_clock) [*4];
  endsequence
  sequence s_high;
    (write_strobe && tx_write_clock) [*4];
  endsequence

  chk_pins_hold_high:
    assert property (tx_write_clock && $past(tx_write_clock) |-> $stable({partition_select,
      write_word, byte_valid_flags, packet_start_mark, packet_end_mark, packet_error_mark,
      write_strobe, logical_port_number, line_terminate}))
    else $error("write pins moved while write clock high");
  chk_wclk_high_phase:
    assert property ($rose(tx_write_clock) |-> tx_write_clock [*4] ##1 !tx_write_clock)
    else $error("write clock high phase length wrong");
  chk_strobe_period:
    assert property ($rose(write_strobe) |-> $fell(tx_write_clock) and (s_low ##1 s_high))
    else $error("strobe not held one write clock period");
  chk_err_with_end:
    assert property (write_strobe && packet_error_mark |-> packet_end_mark)
    else $error("error mark without end mark");
  chk_flags_mid_full:
    assert property (write_strobe && !packet_end_mark |-> byte_valid_flags == 4'hF)
    else $error("partial lane flags before packet end");
  chk_flags_contig:
    assert property (write_strobe |-> byte_valid_flags inside {4'hF, 4'hE, 4'hC, 4'h8})
    else $error("lane flags not contiguous from top");
  chk_sop_line_start:
    assert property (rise && wr && packet_start_mark |-> cnt_r[partition_select] == 2'h0)
    else $error("start mark not on first word of line");
  chk_full_needs_lines:
    assert property (partition_full_flag |-> lines_r[$past(partition_select, 3)] >= FILL)
    else $error("full flag before fill level reached");
endmodule

/* File: tb/tx_packet_fifo_write_port_bench.sv */
`timescale 1ns/100ps
// Writer end facing device end, and a second device end fed by hand-made pins
module tx_packet_fifo_write_port_bench;
  logic         core_clk, rst_b, usr_valid, usr_ready, usr_sop, usr_eop, usr_err, usr_term;
  logic         usr_disable, usr_full;
  logic [31:0]  usr_data;
  logic [3:0]   usr_be;
  logic [7:0]   usr_port;
  logic [2:0]   usr_part;
  logic         lv [2], lrdy [2], ls [2], le [2], lr [2], li [2];
  logic [127:0] ld [2];
  logic [15:0]  lb [2];
  logic [7:0]   lp [2];
  logic [2:0]   lq [2];
  int           mismatches, checks_done;

  tpf_if tif ();
  tpf_if tif2 ();
  tpf_host i_tpf_host (.CORE_CLK(core_clk), .RST_B(rst_b), .wif(tif.host), .USR_VALID(usr_valid),
    .USR_READY(usr_ready), .USR_DATA(usr_data), .USR_BE(usr_be), .USR_SOP(usr_sop),
    .USR_EOP(usr_eop), .USR_ERR(usr_err), .USR_TERM(usr_term), .USR_PORT(usr_port),
    .USR_PART(usr_part), .USR_DISABLE(usr_disable), .USR_FULL(usr_full));
  tpf_dev i_tpf_dev (.CORE_CLK(core_clk), .RST_B(rst_b), .wif(tif.dev), .LINE_READY(lrdy[0]),
    .LINE_VALID(lv[0]), .LINE_DATA(ld[0]), .LINE_BE(lb[0]), .LINE_SOP(ls[0]), .LINE_EOP(le[0]),
    .LINE_ERR(lr[0]), .LINE_PORT(lp[0]), .LINE_PART(lq[0]), .LINK_IDLE(li[0]));
  tpf_dev i_tpf_dev_2 (.CORE_CLK(core_clk), .RST_B(rst_b), .wif(tif2.dev), .LINE_READY(lrdy[1]),
    .LINE_VALID(lv[1]), .LINE_DATA(ld[1]), .LINE_BE(lb[1]), .LINE_SOP(ls[1]), .LINE_EOP(le[1]),
    .LINE_ERR(lr[1]), .LINE_PORT(lp[1]), .LINE_PART(lq[1]), .LINK_IDLE(li[1]));
  tpf_checker i_tpf_checker (.CORE_CLK(core_clk), .RST_B(rst_b),
    .tx_write_clock(tif.tx_write_clock), .partition_select(tif.partition_select),
    .write_word(tif.write_word), .byte_valid_flags(tif.byte_valid_flags),
    .packet_start_mark(tif.packet_start_mark), .packet_end_mark(tif.packet_end_mark),
    .packet_error_mark(tif.packet_error_mark), .write_strobe(tif.write_strobe),
    .logical_port_number(tif.logical_port_number), .line_terminate(tif.line_terminate),
    .buffer_service_disable(tif.buffer_service_disable),
    .partition_full_flag(tif.partition_full_flag));

  // Core clock at 50 MHz
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic cmp(input string nm, input logic [127:0] e, input logic [127:0] g);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Offers one user word; fl is {term, sop, eop, err}; returns on the taking edge
  task automatic send(input logic [31:0] d, input logic [3:0] be, input logic [3:0] fl,
                      input logic [7:0] port, input logic [2:0] part);
    int n;
    n = 0;
    @(negedge core_clk);
    {usr_term, usr_sop, usr_eop, usr_err} = fl;
    {usr_data, usr_be, usr_port, usr_part} = {d, be, port, part};
    usr_valid = 1'b1;
    while (usr_ready !== 1'b1 && n < 400) begin
      @(negedge core_clk);
      n++;
    end
    cmp("offer taken", 128'(1'b1), 128'(usr_ready));
    @(posedge core_clk);
  endtask

  task automatic idle();
    @(negedge core_clk);
    usr_valid = 1'b0;
  endtask

  // Waits for a line, checks it, then takes it; data lanes without a flag are not compared
  task automatic get_line(input int s, input logic [127:0] d, input logic [15:0] be,
                          input logic [2:0] fl, input logic [7:0] port, input logic [2:0] part);
    logic [127:0] m;
    int           n;
    n = 0;
    for (int i = 0; i < 16; i++) m[8*i +: 8] = {8{be[i]}};
    @(negedge core_clk);
    while (lv[s] !== 1'b1 && n < 400) begin
      @(negedge core_clk);
      n++;
    end
    cmp("line valid", 128'(1'b1), 128'(lv[s]));
    cmp("line data", d & m, ld[s] & m);
    cmp("line lanes", 128'(be), 128'(lb[s]));
    cmp("line marks", 128'(fl), 128'({ls[s], le[s], lr[s]}));
    cmp("line port", 128'(port), 128'(lp[s]));
    cmp("line partition", 128'(part), 128'(lq[s]));
    lrdy[s] = 1'b1;
    @(negedge core_clk);
    lrdy[s] = 1'b0;
  endtask

  task automatic wait_full(input logic v);
    int n;
    n = 0;
    while (usr_full !== v && n < 100) begin
      @(negedge core_clk);
      n++;
    end
    cmp("full status", 128'(v), 128'(usr_full));
  endtask

  // One write clock period on the hand-made pins, set 7 ns after a core clock falling edge
  task automatic pin_wr(input logic st, input logic [3:0] be, input logic [31:0] d);
    @(negedge core_clk);
    #7;
    {tif2.write_strobe, tif2.byte_valid_flags, tif2.write_word} = {st, be, d};
    #80 tif2.tx_write_clock = 1'b1;
    #80 tif2.tx_write_clock = 1'b0;
  endtask

  // Watchdog well beyond the expected run time
  initial begin
    #1000000;
    mismatches++;
    conclude();
  end

  // Main sequence
  initial begin
    {rst_b, usr_valid, usr_sop, usr_eop, usr_err, usr_term, usr_disable} = 7'h00;
    {usr_data, usr_be, usr_port, usr_part} = 47'h0;
    lrdy = '{default: 1'b0};
    mismatches = 0;
    checks_done = 0;
    {tif2.tx_write_clock, tif2.partition_select, tif2.packet_error_mark} = 5'h0C;
    {tif2.line_terminate, tif2.buffer_service_disable, tif2.write_strobe} = 3'h0;
    {tif2.packet_start_mark, tif2.packet_end_mark, tif2.logical_port_number} = 10'h35A;
    {tif2.write_word, tif2.byte_valid_flags} = 36'h0;
    repeat (12) @(posedge core_clk);
    @(negedge core_clk);
    rst_b = 1'b1;
    for (int i = 0; i < 4; i++) send(32'hA000_0000 + i, 4'hF, {1'b0, i == 0, i == 3, 1'b0},
                                     8'h21, 3'h0);
    idle();
    get_line(0, 128'hA000_0000_A000_0001_A000_0002_A000_0003, 16'hFFFF, 3'b110, 8'h21,
             3'h0);
    send(32'hB000_0001, 4'hF, 4'b0100, 8'h07, 3'h5);
    send(32'hB000_0002, 4'hE, 4'b0011, 8'h07, 3'h5);
    idle();
    get_line(0, {32'hB000_0001, 32'hB000_0002, 64'h0}, 16'hFE00, 3'b111, 8'h07,
             3'h5);
    send(32'hC100_0000, 4'h8, 4'b0110, 8'h10, 3'h3);
    send(32'hC200_0000, 4'h8, 4'b0110, 8'h11, 3'h3);
    idle();
    get_line(0, {32'hC100_0000, 96'h0}, 16'h8000, 3'b110, 8'h10, 3'h3);
    get_line(0, {32'hC200_0000, 96'h0}, 16'h8000, 3'b110, 8'h11, 3'h3);
    for (int p = 0; p < 8; p++) begin
      send(32'hD000_0000 + p, 4'hF, 4'b0110, 8'h30 + p, p);
      idle();
      get_line(0, {32'hD000_0000 + p, 96'h0}, 16'hF000, 3'b110, 8'h30 + p, p);
    end
    // Terminate mid-line, then a start mark that finds a partly filled line
    send(32'hE000_0001, 4'hF, 4'b0100, 8'h40, 3'h1);
    send(32'hE000_0002, 4'hF, 4'b0000, 8'h40, 3'h1);
    send(32'h0000_0000, 4'hF, 4'b1000, 8'h40, 3'h1);
    send(32'hE000_0003, 4'hF, 4'b0100, 8'h40, 3'h1);
    send(32'hE000_0004, 4'hF, 4'b0110, 8'h40, 3'h1);
    idle();
    get_line(0, {32'hE000_0001, 32'hE000_0002, 64'h0}, 16'hFF00, 3'b100, 8'h40, 3'h1);
    get_line(0, {32'hE000_0003, 96'h0}, 16'hF000, 3'b100, 8'h40, 3'h1);
    get_line(0, {32'hE000_0004, 96'h0}, 16'hF000, 3'b110, 8'h40, 3'h1);
    // Draining stopped while one partition fills to its threshold
    usr_disable = 1'b1;
    repeat (20) @(negedge core_clk);
    for (int i = 0; i < 12; i++) send(32'hF000_0000 + i, 4'hF, 4'b0110, 8'h50, 3'h2);
    idle();
    wait_full(1'b1);
    cmp("link idle", 128'(1'b1), 128'(li[0]));
    cmp("line held back", 128'(1'b0), 128'(lv[0]));
    usr_disable = 1'b0;
    for (int i = 0; i < 12; i++) get_line(0, {32'hF000_0000 + i, 96'h0}, 16'hF000, 3'b110,
                                          8'h50, 3'h2);
    wait_full(1'b0);
    // Second device end: empty flags and strobe-low words must leave no line
    pin_wr(1'b1, 4'h0, 32'h1111_1111);
    pin_wr(1'b0, 4'hF, 32'h2222_2222);
    pin_wr(1'b1, 4'h8, 32'h3333_3333);
    pin_wr(1'b0, 4'h7, 32'hCCCC_CCCC);
    get_line(1, {32'h3333_3333, 96'h0}, 16'h8000, 3'b110, 8'h5A, 3'h6);
    repeat (40) @(negedge core_clk);
    cmp("no extra line", 128'(1'b0), 128'(lv[1]));
    conclude();
  end
endmodule
